// ==== design/jtag_rdbk_pkg.sv ====
// constants, layouts and state types of the jtag readback block
//
// Operation
// R1: readback starts only after an ordered command sequence, then streams the configuration words out one interface.
// R2: readback can be requested and drained over the internal port, the parallel port or the jtag port; the code takes the readback commands over wishbone only.
// R3: with the capture mask written and control_one_reg bit 23 set, the stream carries the current register state.
// R4: there are no snapshot cells, so a global snapshot command is refused and no snapshot primitive exists.
// R5: user logic keeps the clocks of captured elements stopped for the whole readback sequence.
// R6: captured logic-block register bits come back inverted, block and lut memory bits come back as stored.
// R7: the counter is clocked only under the fourth user scan instruction in run-test/idle with tms low.
// R8: the 8-bit count equals the number of test clocks given in run-test/idle while counting is enabled.
// R9: the host shifts in the fourth user scan instruction before it gives the run-test/idle clocks.
// R10: with the counter reset input low, one gated test clock in run-test/idle clears the counter.
// R11: each counter bit drives one indicator output at all times.
// R12: mode pins at 101 make jtag the configuration interface.
// R13: the counter clock stops as soon as the instruction changes or run-test/idle with tms low ends.
// R14: each enabled gated clock edge with reset inactive adds one and wraps from all ones to zero.
package jtag_rdbk_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_ONE_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h04;
  localparam logic [7:0] CMD_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] RDBK_DATA_OFS = 8'h10;
  localparam logic [7:0] CFG_LOAD_OFS = 8'h14;
  localparam logic [31:0] CTRL_ONE_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam int CAPTURE_EN_BIT = 23;
  localparam int PAR_PATH_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SYNCED_BIT = 1;
  localparam int ST_SEQ_ERR_BIT = 2;
  localparam int ST_UNSUP_BIT = 3;
  localparam int ST_JTAG_MODE_BIT = 4;
  localparam int ST_COUNT_LSB = 8;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SYNC = 8'h01;
  localparam logic [7:0] CMD_READBACK = 8'h02;
  localparam logic [7:0] CMD_DESYNC = 8'h03;
  localparam logic [7:0] CMD_GLOBAL_SNAPSHOT = 8'h0c;
  // ----------------------------------------------------------------
  // jtag instructions and mode pins
  // ----------------------------------------------------------------
  localparam int IR_LEN = 6;
  localparam logic [5:0] IR_USER_SCAN_FOUR = 6'h23;
  localparam logic [5:0] IR_CFG_OUT = 6'h04;
  localparam logic [5:0] IR_BYPASS = 6'h3f;
  localparam logic [5:0] IR_CAPTURE_PAT = 6'h01;
  localparam logic [2:0] MODE_JTAG = 3'h5;
  localparam int COUNT_W = 8;
  localparam int CFG_WORDS = 4;
  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
    TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020, TAP_PAU_DR = 16'h0040, TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100, TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PAU_IR = 16'h2000, TAP_EX2_IR = 16'h4000, TAP_UPD_IR = 16'h8000
  } tap_state_e;
  typedef enum logic [2:0] {RB_IDLE = 3'h1, RB_SYNCED = 3'h2, RB_STREAM = 3'h4} rb_state_e;
  typedef enum logic [2:0] {PATH_INTERNAL = 3'h1, PATH_PARALLEL = 3'h2, PATH_JTAG = 3'h4} rb_path_e;
endpackage : jtag_rdbk_pkg

// ==== design/counter_link_if.sv ====
// link between the tap control logic and the gated counter
`timescale 1ns/1ps
interface counter_link_if #(parameter int WIDTH = 8);
  logic tick;
  logic enable;
  logic clear;
  logic [WIDTH-1:0] count;
  modport ctl (output tick, output enable, output clear, input count);
  modport cnt (input tick, input enable, input clear, output count);
endinterface : counter_link_if

// ==== design/gated_counter.sv ====
// counter advanced only by gated test clock edges
`timescale 1ns/1ps
module gated_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // control and count
  counter_link_if.cnt lnk
);
  // ----------------------------------------------------------------
  // count register
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      lnk.count <= '0;
    end else if (lnk.tick && lnk.enable) begin // R7
      if (lnk.clear) begin
        lnk.count <= '0; // R10
      end else begin
        lnk.count <= lnk.count + 1'b1; // R8 R14
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_count_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R7
    !(lnk.tick && lnk.enable) |=> $stable(lnk.count))
    else $error("count moved without an enabled gated edge");
  a_count_step: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R14
    lnk.tick && lnk.enable && !lnk.clear |=> lnk.count == WIDTH'($past(lnk.count) + 1'b1))
    else $error("count did not advance by one");
  a_count_clear: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R10
    lnk.tick && lnk.enable && lnk.clear |=> lnk.count == '0)
    else $error("count not cleared by gated edge");
  c_count_wrap: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    lnk.count == '1 ##1 lnk.count == '0);
endmodule : gated_counter

// ==== design/jtag_rdbk_top.sv ====
// jtag tap, gated counter and configuration readback engine
`timescale 1ns/1ps
module jtag_rdbk_top #(
  parameter int CFG_WORDS = jtag_rdbk_pkg::CFG_WORDS,
  parameter int COUNT_W = jtag_rdbk_pkg::COUNT_W
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // jtag pins
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  // mode pins and counter reset pin
  input wire logic [2:0] i_mode_pins,
  input wire logic i_count_rst_n,
  // parallel readback port
  input wire logic i_par_ready,
  output logic [31:0] o_par_data,
  output logic o_par_valid,
  // same-domain memory state for capture
  input wire logic [7:0] i_bram_state,
  input wire logic [7:0] i_lutram_state,
  // indicators
  output logic [COUNT_W-1:0] o_led
);
  localparam int IDX_W = $clog2(CFG_WORDS + 2);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic tck_d;
  logic par_ready_d;
  logic tck_s, tms_s, tdi_s, count_rst_n_s, par_ready_s;
  logic [2:0] mode_s;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sync_a <= 8'h08;
      sync_b <= 8'h08;
      tck_d <= 1'b0;
      par_ready_d <= 1'b0;
    end else begin
      sync_a <= {i_mode_pins, i_par_ready, i_count_rst_n, i_tdi, i_tms, i_tck};
      sync_b <= sync_a;
      tck_d <= sync_b[0];
      par_ready_d <= sync_b[4];
    end
  end

  assign {mode_s, par_ready_s, count_rst_n_s, tdi_s, tms_s, tck_s} = sync_b;
  wire tck_rise = tck_s && !tck_d;
  wire tck_fall = !tck_s && tck_d;
  wire par_ready_rise = par_ready_s && !par_ready_d;
  wire mode_jtag = (mode_s == jtag_rdbk_pkg::MODE_JTAG); // R12

  // ----------------------------------------------------------------
  // tap controller
  // ----------------------------------------------------------------
  jtag_rdbk_pkg::tap_state_e tap;
  logic [jtag_rdbk_pkg::IR_LEN-1:0] ir;
  logic [jtag_rdbk_pkg::IR_LEN-1:0] ir_sr;
  logic [31:0] dr_sr;

  function automatic jtag_rdbk_pkg::tap_state_e tap_next(input jtag_rdbk_pkg::tap_state_e s, input logic m);
    jtag_rdbk_pkg::tap_state_e n;
    n = jtag_rdbk_pkg::TAP_RESET;
    unique case (s)
      jtag_rdbk_pkg::TAP_RESET: n = m ? jtag_rdbk_pkg::TAP_RESET : jtag_rdbk_pkg::TAP_IDLE;
      jtag_rdbk_pkg::TAP_IDLE: n = m ? jtag_rdbk_pkg::TAP_SEL_DR : jtag_rdbk_pkg::TAP_IDLE;
      jtag_rdbk_pkg::TAP_SEL_DR: n = m ? jtag_rdbk_pkg::TAP_SEL_IR : jtag_rdbk_pkg::TAP_CAP_DR;
      jtag_rdbk_pkg::TAP_CAP_DR: n = m ? jtag_rdbk_pkg::TAP_EX1_DR : jtag_rdbk_pkg::TAP_SH_DR;
      jtag_rdbk_pkg::TAP_SH_DR: n = m ? jtag_rdbk_pkg::TAP_EX1_DR : jtag_rdbk_pkg::TAP_SH_DR;
      jtag_rdbk_pkg::TAP_EX1_DR: n = m ? jtag_rdbk_pkg::TAP_UPD_DR : jtag_rdbk_pkg::TAP_PAU_DR;
      jtag_rdbk_pkg::TAP_PAU_DR: n = m ? jtag_rdbk_pkg::TAP_EX2_DR : jtag_rdbk_pkg::TAP_PAU_DR;
      jtag_rdbk_pkg::TAP_EX2_DR: n = m ? jtag_rdbk_pkg::TAP_UPD_DR : jtag_rdbk_pkg::TAP_SH_DR;
      jtag_rdbk_pkg::TAP_UPD_DR: n = m ? jtag_rdbk_pkg::TAP_SEL_DR : jtag_rdbk_pkg::TAP_IDLE;
      jtag_rdbk_pkg::TAP_SEL_IR: n = m ? jtag_rdbk_pkg::TAP_RESET : jtag_rdbk_pkg::TAP_CAP_IR;
      jtag_rdbk_pkg::TAP_CAP_IR: n = m ? jtag_rdbk_pkg::TAP_EX1_IR : jtag_rdbk_pkg::TAP_SH_IR;
      jtag_rdbk_pkg::TAP_SH_IR: n = m ? jtag_rdbk_pkg::TAP_EX1_IR : jtag_rdbk_pkg::TAP_SH_IR;
      jtag_rdbk_pkg::TAP_EX1_IR: n = m ? jtag_rdbk_pkg::TAP_UPD_IR : jtag_rdbk_pkg::TAP_PAU_IR;
      jtag_rdbk_pkg::TAP_PAU_IR: n = m ? jtag_rdbk_pkg::TAP_EX2_IR : jtag_rdbk_pkg::TAP_PAU_IR;
      jtag_rdbk_pkg::TAP_EX2_IR: n = m ? jtag_rdbk_pkg::TAP_UPD_IR : jtag_rdbk_pkg::TAP_SH_IR;
      jtag_rdbk_pkg::TAP_UPD_IR: n = m ? jtag_rdbk_pkg::TAP_SEL_DR : jtag_rdbk_pkg::TAP_IDLE;
    endcase
    return n;
  endfunction : tap_next

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      tap <= jtag_rdbk_pkg::TAP_RESET;
    end else if (tck_rise) begin
      tap <= tap_next(tap, tms_s);
    end
  end

  // instruction register; update replaces the active instruction at once
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ir <= jtag_rdbk_pkg::IR_BYPASS;
      ir_sr <= '0;
    end else if (tck_rise) begin
      unique case (tap)
        jtag_rdbk_pkg::TAP_RESET: ir <= jtag_rdbk_pkg::IR_BYPASS;
        jtag_rdbk_pkg::TAP_CAP_IR: ir_sr <= jtag_rdbk_pkg::IR_CAPTURE_PAT;
        jtag_rdbk_pkg::TAP_SH_IR: ir_sr <= {tdi_s, ir_sr[jtag_rdbk_pkg::IR_LEN-1:1]};
        jtag_rdbk_pkg::TAP_UPD_IR: ir <= ir_sr; // R9 R13
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // gated counter
  // ----------------------------------------------------------------
  counter_link_if #(.WIDTH(COUNT_W)) cnt_lnk ();

  wire user_four_active = (ir == jtag_rdbk_pkg::IR_USER_SCAN_FOUR);
  // tms is taken with the edge: a high tms edge leaves idle and is not counted
  assign cnt_lnk.enable = user_four_active && (tap == jtag_rdbk_pkg::TAP_IDLE) && !tms_s; // R7 R13
  assign cnt_lnk.tick = tck_rise; // R8
  assign cnt_lnk.clear = !count_rst_n_s; // R10

  gated_counter #(.WIDTH(COUNT_W)) u_counter (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .lnk(cnt_lnk)
  );

  assign o_led = cnt_lnk.count; // R11

  // ----------------------------------------------------------------
  // wishbone registers
  // ----------------------------------------------------------------
  logic [31:0] control_one_reg;
  logic [31:0] capture_mask_reg;
  logic seq_err;
  logic unsup_err;
  logic [31:0] status_word;

  wire wb_req = i_wb_cyc && i_wb_stb;
  wire wb_wr = wb_req && o_wb_ack && i_wb_we;
  wire wb_rd = wb_req && o_wb_ack && !i_wb_we;

  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge_sel

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      control_one_reg <= jtag_rdbk_pkg::CTRL_ONE_RST;
      capture_mask_reg <= jtag_rdbk_pkg::MASK_RST;
    end else if (wb_wr) begin
      if (i_wb_adr == jtag_rdbk_pkg::CTRL_ONE_OFS) begin
        control_one_reg <= merge_sel(control_one_reg, i_wb_dat, i_wb_sel); // R3
      end
      if (i_wb_adr == jtag_rdbk_pkg::MASK_OFS) begin
        capture_mask_reg <= merge_sel(capture_mask_reg, i_wb_dat, i_wb_sel); // R3
      end
    end
  end

  // ----------------------------------------------------------------
  // readback engine
  // ----------------------------------------------------------------
  jtag_rdbk_pkg::rb_state_e rb_state;
  jtag_rdbk_pkg::rb_path_e rb_path;
  logic [31:0] cfg_mem [CFG_WORDS];
  logic [IDX_W-1:0] cfg_wptr;
  logic [IDX_W-1:0] rb_idx;
  logic [IDX_W-1:0] rb_total;
  logic [31:0] capture_word;
  logic [31:0] rb_word;

  wire cmd_wr = wb_wr && (i_wb_adr == jtag_rdbk_pkg::CMD_OFS) && i_wb_sel[0];
  wire [7:0] cmd_code = i_wb_dat[7:0];
  wire streaming = (rb_state == jtag_rdbk_pkg::RB_STREAM);
  wire rb_start = cmd_wr && (cmd_code == jtag_rdbk_pkg::CMD_READBACK) && (rb_state == jtag_rdbk_pkg::RB_SYNCED);
  wire pop_int = wb_rd && (i_wb_adr == jtag_rdbk_pkg::RDBK_DATA_OFS) && (rb_path == jtag_rdbk_pkg::PATH_INTERNAL);
  wire pop_par = par_ready_rise && (rb_path == jtag_rdbk_pkg::PATH_PARALLEL);
  wire pop_jtag = tck_rise && (tap == jtag_rdbk_pkg::TAP_UPD_DR) && (ir == jtag_rdbk_pkg::IR_CFG_OUT)
                  && (rb_path == jtag_rdbk_pkg::PATH_JTAG);
  wire rb_pop = streaming && (pop_int || pop_par || pop_jtag); // R2

  // logic-block bits inverted, memory bits as stored; the clock must already be frozen
  assign capture_word = {8'h00, i_lutram_state, i_bram_state, ~cnt_lnk.count} & capture_mask_reg; // R6
  assign rb_word = (rb_idx < IDX_W'(CFG_WORDS)) ? cfg_mem[rb_idx[$clog2(CFG_WORDS)-1:0]] : capture_word;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rb_state <= jtag_rdbk_pkg::RB_IDLE;
      rb_path <= jtag_rdbk_pkg::PATH_INTERNAL;
      rb_idx <= '0;
      rb_total <= '0;
    end else if (cmd_wr && cmd_code == jtag_rdbk_pkg::CMD_DESYNC) begin
      rb_state <= jtag_rdbk_pkg::RB_IDLE;
    end else if (cmd_wr && cmd_code == jtag_rdbk_pkg::CMD_SYNC && rb_state == jtag_rdbk_pkg::RB_IDLE) begin
      rb_state <= jtag_rdbk_pkg::RB_SYNCED; // R1
    end else if (rb_start) begin
      rb_state <= jtag_rdbk_pkg::RB_STREAM; // R1
      rb_idx <= '0;
      rb_total <= IDX_W'(CFG_WORDS) + IDX_W'(control_one_reg[jtag_rdbk_pkg::CAPTURE_EN_BIT]); // R3
      if (mode_jtag) begin
        rb_path <= jtag_rdbk_pkg::PATH_JTAG; // R12
      end else if (control_one_reg[jtag_rdbk_pkg::PAR_PATH_BIT]) begin
        rb_path <= jtag_rdbk_pkg::PATH_PARALLEL;
      end else begin
        rb_path <= jtag_rdbk_pkg::PATH_INTERNAL;
      end
    end else if (rb_pop) begin
      rb_idx <= rb_idx + 1'b1;
      if (rb_idx + 1'b1 == rb_total) begin
        rb_state <= jtag_rdbk_pkg::RB_IDLE;
      end
    end
  end

  // configuration words loaded in order while synced
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cfg_wptr <= '0;
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_mem[i] <= '0;
      end
    end else if (cmd_wr && cmd_code == jtag_rdbk_pkg::CMD_SYNC) begin
      cfg_wptr <= '0;
    end else if (wb_wr && i_wb_adr == jtag_rdbk_pkg::CFG_LOAD_OFS && rb_state == jtag_rdbk_pkg::RB_SYNCED
                 && cfg_wptr < IDX_W'(CFG_WORDS)) begin
      cfg_mem[cfg_wptr[$clog2(CFG_WORDS)-1:0]] <= i_wb_dat;
      cfg_wptr <= cfg_wptr + 1'b1;
    end
  end

  // error flags: write one to clear, a new event in the same cycle wins
  wire st_clr = wb_wr && (i_wb_adr == jtag_rdbk_pkg::STATUS_OFS) && i_wb_sel[0];
  wire seq_set = cmd_wr && (cmd_code == jtag_rdbk_pkg::CMD_READBACK) && !rb_start; // R1
  wire unsup_set = cmd_wr && (cmd_code == jtag_rdbk_pkg::CMD_GLOBAL_SNAPSHOT); // R4

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      seq_err <= 1'b0;
      unsup_err <= 1'b0;
    end else begin
      seq_err <= seq_set || (seq_err && !(st_clr && i_wb_dat[jtag_rdbk_pkg::ST_SEQ_ERR_BIT]));
      unsup_err <= unsup_set || (unsup_err && !(st_clr && i_wb_dat[jtag_rdbk_pkg::ST_UNSUP_BIT]));
    end
  end

  always_comb begin
    status_word = '0;
    status_word[jtag_rdbk_pkg::ST_BUSY_BIT] = streaming;
    status_word[jtag_rdbk_pkg::ST_SYNCED_BIT] = (rb_state == jtag_rdbk_pkg::RB_SYNCED);
    status_word[jtag_rdbk_pkg::ST_SEQ_ERR_BIT] = seq_err;
    status_word[jtag_rdbk_pkg::ST_UNSUP_BIT] = unsup_err;
    status_word[jtag_rdbk_pkg::ST_JTAG_MODE_BIT] = mode_jtag;
    status_word[jtag_rdbk_pkg::ST_COUNT_LSB +: COUNT_W] = cnt_lnk.count;
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= wb_req && !o_wb_ack;
      if (wb_req && !o_wb_ack) begin
        unique case (i_wb_adr)
          jtag_rdbk_pkg::CTRL_ONE_OFS: o_wb_dat <= control_one_reg;
          jtag_rdbk_pkg::MASK_OFS: o_wb_dat <= capture_mask_reg;
          jtag_rdbk_pkg::STATUS_OFS: o_wb_dat <= status_word;
          jtag_rdbk_pkg::RDBK_DATA_OFS: o_wb_dat <= streaming ? rb_word : 32'h0000_0000;
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // jtag data register and tdo
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      dr_sr <= '0;
    end else if (tck_rise) begin
      if (tap == jtag_rdbk_pkg::TAP_CAP_DR) begin
        if (ir == jtag_rdbk_pkg::IR_CFG_OUT) begin
          dr_sr <= (streaming && rb_path == jtag_rdbk_pkg::PATH_JTAG) ? rb_word : 32'h0000_0000;
        end else if (user_four_active) begin
          dr_sr <= 32'(cnt_lnk.count);
        end else begin
          dr_sr <= '0;
        end
      end else if (tap == jtag_rdbk_pkg::TAP_SH_DR) begin
        // bypass is a single bit, other data registers are full words
        dr_sr <= (ir == jtag_rdbk_pkg::IR_BYPASS) ? {31'h0000_0000, tdi_s} : {tdi_s, dr_sr[31:1]};
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      o_tdo <= (tap == jtag_rdbk_pkg::TAP_SH_IR) ? ir_sr[0] : dr_sr[0];
      o_tdo_oe <= (tap == jtag_rdbk_pkg::TAP_SH_IR) || (tap == jtag_rdbk_pkg::TAP_SH_DR);
    end
  end

  // ----------------------------------------------------------------
  // parallel port
  // ----------------------------------------------------------------
  assign o_par_valid = streaming && (rb_path == jtag_rdbk_pkg::PATH_PARALLEL);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_par_data <= '0;
    end else begin
      o_par_data <= rb_word;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_gate_other_instr: assert property (!user_four_active || tap != jtag_rdbk_pkg::TAP_IDLE |-> !cnt_lnk.enable) // R13
    else $error("counter enabled outside idle under user instruction four");
  a_led_follows: assert property (cnt_lnk.tick && cnt_lnk.enable |=> o_led != $past(o_led) || !count_rst_n_s) // R11
    else $error("indicators did not follow the count");
  a_order_needed: assert property (cmd_wr && cmd_code == jtag_rdbk_pkg::CMD_READBACK
    && rb_state == jtag_rdbk_pkg::RB_IDLE |=> !streaming && seq_err) // R1
    else $error("readback started without sync");
  a_snapshot_refused: assert property (unsup_set && !streaming |=> !streaming && unsup_err) // R4
    else $error("global snapshot command not refused");
  a_capture_length: assert property (rb_start |=> rb_total == IDX_W'(CFG_WORDS)
    + IDX_W'($past(control_one_reg[jtag_rdbk_pkg::CAPTURE_EN_BIT]))) // R3
    else $error("capture word count wrong");
  a_capture_invert: assert property (streaming && rb_idx == IDX_W'(CFG_WORDS) |->
    rb_word[23:0] == ({i_lutram_state, i_bram_state, ~cnt_lnk.count} & capture_mask_reg[23:0])) // R6
    else $error("captured polarity wrong");
  a_mode_jtag_path: assert property (rb_start && mode_jtag |=> rb_path == jtag_rdbk_pkg::PATH_JTAG) // R12
    else $error("mode 101 did not select jtag");
  a_stream_ends: assert property (rb_pop && rb_idx + 1'b1 == rb_total |=> rb_state == jtag_rdbk_pkg::RB_IDLE) // R2
    else $error("stream did not end after last word");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held two cycles");

  c_count_runs: cover property (cnt_lnk.enable && cnt_lnk.tick ##1 cnt_lnk.enable && cnt_lnk.tick);
  c_jtag_pop: cover property (rb_pop && pop_jtag);
  c_stream_done: cover property (streaming ##1 rb_state == jtag_rdbk_pkg::RB_IDLE);
  c_snapshot: cover property (unsup_set);
endmodule : jtag_rdbk_top

// ==== bench/jtag_host.sv ====
// jtag host model: instruction shifts and idle clocks
`timescale 1ns/1ps
module jtag_host (
  // jtag pins
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input logic i_tdo
);
  // tdo as seen just before the last rising tck
  logic seen;
  // tck stands low between frames
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  task automatic tick(input logic tms, input logic tdi);
    o_tms = tms;
    o_tdi = tdi;
    #80 seen = i_tdo;
    o_tck = 1'b1;
    #80 o_tck = 1'b0;
    o_tdi = ~tdi;
  endtask : tick
  task automatic reset_tap();
    repeat (5) tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask : reset_tap
  // from idle: ir lsb first, back to idle
  task automatic load_ir(input logic [5:0] ir);
    tick(1'b1, 1'b0);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    for (int i = 0; i < 6; i++) tick(i == 5, ir[i]);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask : load_ir
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) tick(1'b0, 1'b0);
  endtask : idle_clocks
  // from idle: capture, 32 bits lsb first, update, back to idle
  task automatic read_dr(output logic [31:0] d);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    for (int i = 0; i < 32; i++) begin
      tick(i == 31, 1'b0);
      d[i] = seen;
    end
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask : read_dr
endmodule : jtag_host

// ==== bench/tb_top.sv ====
// self-checking bench of the jtag readback block
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, rst_n = 1, pr = 0;
  logic [7:0] adr = 0, led, bram = 8'h5a, lut = 8'hc3;
  logic [31:0] wd = 0, rd, q;
  logic [2:0] mode = 3'h5;
  wire tck, tms, tdi, tdo, tdo_oe, pv;
  wire [31:0] pd;
  int miscompares = 0, comparisons = 0, cycles = 0;
  jtag_host i_jtag_host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
  jtag_rdbk_top i_jtag_rdbk_top (.i_ref_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wd), .o_wb_dat(rd), .o_wb_ack(ack),
    .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_mode_pins(mode),
    .i_count_rst_n(rst_n), .i_par_ready(pr), .o_par_data(pd), .o_par_valid(pv),
    .i_bram_state(bram), .i_lutram_state(lut), .o_led(led));
  initial forever #10 clk = ~clk;
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask : wb
  task automatic led_is(input logic [7:0] e);
    repeat (8) @(posedge clk);
    chk("led", {24'h0, e}, {24'h0, led});
  endtask : led_is
  task automatic t_count();
    i_jtag_host.reset_tap();
    i_jtag_host.load_ir(jtag_rdbk_pkg::IR_USER_SCAN_FOUR);
    i_jtag_host.idle_clocks(5);
    led_is(8'h05);
    i_jtag_host.read_dr(q);
    chk("count dr", 32'h05, q);
    chk("tdo enable", 32'h0, {31'h0, tdo_oe});
    i_jtag_host.load_ir(jtag_rdbk_pkg::IR_BYPASS);
    i_jtag_host.idle_clocks(3);
    led_is(8'h05);
    i_jtag_host.load_ir(jtag_rdbk_pkg::IR_USER_SCAN_FOUR);
    i_jtag_host.idle_clocks(251);
    led_is(8'h00);
    i_jtag_host.idle_clocks(2);
    rst_n <= 0;
    i_jtag_host.idle_clocks(1);
    led_is(8'h00);
    rst_n <= 1;
    $display("count test done");
  endtask : t_count
  task automatic t_regs();
    wb(0, jtag_rdbk_pkg::STATUS_OFS, 0);
    chk("jtag mode", 32'h10, q & 32'h10);
    wb(1, jtag_rdbk_pkg::CMD_OFS, 32'h0c);
    wb(1, jtag_rdbk_pkg::CMD_OFS, 32'h02);
    wb(0, jtag_rdbk_pkg::STATUS_OFS, 0);
    chk("errors", 32'h0c, q & 32'h0e);
    wb(1, jtag_rdbk_pkg::STATUS_OFS, 32'h0c);
    wb(0, jtag_rdbk_pkg::STATUS_OFS, 0);
    chk("errors cleared", 32'h00, q & 32'h0c);
    $display("register test done");
  endtask : t_regs
  task automatic start_rb(input logic [31:0] ctrl);
    wb(1, jtag_rdbk_pkg::CTRL_ONE_OFS, ctrl);
    wb(1, jtag_rdbk_pkg::MASK_OFS, 32'hffff_ffff);
    wb(1, jtag_rdbk_pkg::CMD_OFS, 32'h01);
    for (int i = 0; i < 4; i++) wb(1, jtag_rdbk_pkg::CFG_LOAD_OFS, 32'ha5a5_0000 + 32'(i));
    wb(1, jtag_rdbk_pkg::CMD_OFS, 32'h02);
  endtask : start_rb
  task automatic t_jtag_rb();
    start_rb(32'h0080_0000);
    i_jtag_host.load_ir(jtag_rdbk_pkg::IR_CFG_OUT);
    for (int i = 0; i < 4; i++) begin
      i_jtag_host.read_dr(q);
      chk("jtag word", 32'ha5a5_0000 + 32'(i), q);
    end
    i_jtag_host.read_dr(q);
    chk("jtag capture", 32'h00c3_5aff, q);
    wb(0, jtag_rdbk_pkg::STATUS_OFS, 0);
    chk("busy", 32'h0, q & 32'h1);
    $display("jtag readback test done");
  endtask : t_jtag_rb
  task automatic t_int_rb();
    mode <= 3'h0;
    start_rb(32'h0080_0000);
    for (int i = 0; i < 4; i++) begin
      wb(0, jtag_rdbk_pkg::RDBK_DATA_OFS, 0);
      chk("word", 32'ha5a5_0000 + 32'(i), q);
    end
    wb(0, jtag_rdbk_pkg::RDBK_DATA_OFS, 0);
    chk("capture", 32'h00c3_5aff, q);
    $display("internal readback test done");
  endtask : t_int_rb
  task automatic t_par_rb();
    start_rb(32'h0000_0001);
    @(posedge clk);
    chk("par valid", 32'h1, {31'h0, pv});
    for (int i = 0; i < 4; i++) begin
      chk("par word", 32'ha5a5_0000 + 32'(i), pd);
      pr <= 1;
      repeat (4) @(posedge clk);
      pr <= 0;
      repeat (4) @(posedge clk);
    end
    chk("par end", 32'h0, {31'h0, pv});
    $display("parallel readback test done");
  endtask : t_par_rb
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_count();
    @(posedge clk);
    t_regs();
    t_jtag_rb();
    t_int_rb();
    t_par_rb();
    print_verdict();
  end
endmodule : tb_top
